/* hw/pto_ctrl.sv */
// PHY tuning override control register with per-port PHY setting selection
`timescale 1ns/1ps
// Summary of operation
// (R1) With bit 16 set, port 3 de-emphasis comes from its value field, else the default.
// (R2) On the two-port variant the port 3 bits store writes but never change a PHY setting.
// (R3) Reserved bits 15:11 and 7:3 (and the other reserved bits) ignore writes and read zero.
// (R4) With bit 10 set, port 2 equalization takes both functional and initial values.
// (R5) With bit 9 set, port 2 swing comes from its value field.
// (R6) With bit 8 set, port 2 de-emphasis comes from its value field.
// (R7) With bit 2 set, port 1 equalization takes both functional and initial values.
// (R8) With bit 1 set, port 1 swing comes from its value field.
// (R9) With bit 0 set, port 1 de-emphasis comes from its value field.
// (R10) Fundamental reset, global reset or power-on reset clears every override bit.
// (R11) Equalizer value bits 7:4 are the initial value and 3:0 the functional value.
// (R12) Bits 26:24 are the port 4 overrides, inert on the two-port variant.
// (R13) The register sits at configuration offset ech, read/write, reset value zero.
// (R14) A clear override bit gives the PHY the built-in default whatever the value field holds.
module pto_ctrl #(
	parameter int NUM_PORTS = 4,
	parameter int DE_W = 4,
	parameter int AMP_W = 4
) (
	// Clock and resets
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic fundamental_resetn_i,
	input wire logic global_reset_in_n_i,
	// Configuration access
	input wire logic [11:0] cfg_addr_i,
	input wire logic cfg_wr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	input wire logic cfg_rd_i,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_hit_o,
	// Override values from companion registers, port n in slice n-1
	input wire logic [pto_pkg::PTO_MAX_PORTS*DE_W-1:0] deemph_value_i,
	input wire logic [pto_pkg::PTO_MAX_PORTS*AMP_W-1:0] tx_amplitude_value_i,
	input wire logic [pto_pkg::PTO_MAX_PORTS*2*pto_pkg::PTO_EQ_W-1:0] equalize_value_i,
	// Built-in defaults
	input wire logic [pto_pkg::PTO_MAX_PORTS*DE_W-1:0] deemph_default_i,
	input wire logic [pto_pkg::PTO_MAX_PORTS*AMP_W-1:0] tx_amplitude_default_i,
	input wire logic [pto_pkg::PTO_MAX_PORTS*2*pto_pkg::PTO_EQ_W-1:0] equalize_default_i,
	// PHY tuning outputs
	output logic [pto_pkg::PTO_MAX_PORTS*DE_W-1:0] phy_deemph_o,
	output logic [pto_pkg::PTO_MAX_PORTS*AMP_W-1:0] phy_tx_amplitude_o,
	output logic [pto_pkg::PTO_MAX_PORTS*pto_pkg::PTO_EQ_W-1:0] phy_equalize_functional_o,
	output logic [pto_pkg::PTO_MAX_PORTS*pto_pkg::PTO_EQ_W-1:0] phy_equalize_initial_o
);
	import pto_pkg::*;

	// ==========================================================
	// Parameter checks
	// Refused at elaboration, so a bad variant never builds
	if (NUM_PORTS != PTO_SMALL_PORTS && NUM_PORTS != PTO_MAX_PORTS) begin : g_bad_ports
		$error("NUM_PORTS must be 2 or 4");
	end
	if (DE_W < 1 || AMP_W < 1) begin : g_bad_widths
		$error("value widths must be positive");
	end

	// ==========================================================
	// Reset combine
	// Any of the three resets clears the register; glitch-free AND of active-low sources
	logic rst_n;
	assign rst_n = resetn_i & fundamental_resetn_i & global_reset_in_n_i; // R10

	// ==========================================================
	// Register
	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [31:0] be_mask;
	logic sel;

	assign sel = (cfg_addr_i[11:2] == PTO_CTRL_OFFSET[11:2]); // R13
	assign cfg_hit_o = sel & (cfg_wr_i | cfg_rd_i);
	assign be_mask = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};

	always_comb begin
		ctrl_d = ctrl_q;
		if (sel && cfg_wr_i) begin
			// Only override bits take writes, reserved stay zero
			ctrl_d = (ctrl_q & ~(be_mask & PTO_CTRL_WMASK)) |
				(cfg_wdata_i & be_mask & PTO_CTRL_WMASK); // R3
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= PTO_CTRL_RESET; // R10
		end else begin
			ctrl_q <= ctrl_d; // R2
		end
	end

	// Registered read data
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rdata_o <= 32'h0000_0000;
		end else if (sel && cfg_rd_i) begin
			cfg_rdata_o <= ctrl_q & PTO_CTRL_WMASK; // R3
		end else if (cfg_rd_i) begin
			cfg_rdata_o <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// Per-port selection
	localparam int BASES [PTO_MAX_PORTS] = '{PTO_P1_BASE, PTO_P2_BASE, PTO_P3_BASE, PTO_P4_BASE};
	for (genvar p = 0; p < PTO_MAX_PORTS; p++) begin : g_port
		pto_port_sel #(
			.DE_W(DE_W),
			.AMP_W(AMP_W)
		) u_sel (
			.present_i(1'(p < NUM_PORTS)), // R2 R12
			.deemph_override_en_i(ctrl_q[BASES[p] + PTO_DE_OFS]), // R1 R6 R9
			.tx_amplitude_override_en_i(ctrl_q[BASES[p] + PTO_AMP_OFS]), // R5 R8
			.rx_equalize_override_en_i(ctrl_q[BASES[p] + PTO_EQ_OFS]), // R4 R7
			.deemph_value_i(deemph_value_i[p*DE_W +: DE_W]),
			.tx_amplitude_value_i(tx_amplitude_value_i[p*AMP_W +: AMP_W]),
			.equalize_value_i(equalize_value_i[p*2*PTO_EQ_W +: 2*PTO_EQ_W]), // R11
			.deemph_default_i(deemph_default_i[p*DE_W +: DE_W]), // R14
			.tx_amplitude_default_i(tx_amplitude_default_i[p*AMP_W +: AMP_W]),
			.equalize_default_i(equalize_default_i[p*2*PTO_EQ_W +: 2*PTO_EQ_W]),
			.deemph_o(phy_deemph_o[p*DE_W +: DE_W]),
			.tx_amplitude_o(phy_tx_amplitude_o[p*AMP_W +: AMP_W]),
			.equalize_functional_o(phy_equalize_functional_o[p*PTO_EQ_W +: PTO_EQ_W]),
			.equalize_initial_o(phy_equalize_initial_o[p*PTO_EQ_W +: PTO_EQ_W])
		);
	end

	// ==========================================================
	// Checks
	// Fixed bit positions here, so a wrong BASES entry cannot hide itself
	chk_p1_deemph_sel: assert property (@(posedge clock_i) disable iff (!rst_n) // R9
		phy_deemph_o[DE_W-1:0] == (ctrl_q[0] ? deemph_value_i[DE_W-1:0]
			: deemph_default_i[DE_W-1:0])) else $error("port 1 de-emphasis wrong");
	chk_p1_amp_sel: assert property (@(posedge clock_i) disable iff (!rst_n) // R8
		!ctrl_q[1] |-> phy_tx_amplitude_o[AMP_W-1:0] == tx_amplitude_default_i[AMP_W-1:0])
		else $error("port 1 swing not default");
	chk_p1_amp_ovr: assert property (@(posedge clock_i) disable iff (!rst_n) // R8
		ctrl_q[1] |-> phy_tx_amplitude_o[AMP_W-1:0] == tx_amplitude_value_i[AMP_W-1:0])
		else $error("port 1 swing not overridden");
	chk_p1_eq_sel: assert property (@(posedge clock_i) disable iff (!rst_n) // R7 R11
		ctrl_q[2] |-> phy_equalize_initial_o[3:0] == equalize_value_i[7:4]
			&& phy_equalize_functional_o[3:0] == equalize_value_i[3:0])
		else $error("port 1 equalizer wrong");
	chk_p2_deemph_sel: assert property (@(posedge clock_i) disable iff (!rst_n) // R6
		ctrl_q[8] |-> phy_deemph_o[DE_W +: DE_W] == deemph_value_i[DE_W +: DE_W])
		else $error("port 2 de-emphasis wrong");
	chk_p2_amp_sel: assert property (@(posedge clock_i) disable iff (!rst_n) // R5
		ctrl_q[9] |-> phy_tx_amplitude_o[AMP_W +: AMP_W] == tx_amplitude_value_i[AMP_W +: AMP_W])
		else $error("port 2 swing wrong");
	chk_p2_eq_sel: assert property (@(posedge clock_i) disable iff (!rst_n) // R4 R11
		ctrl_q[10] |-> phy_equalize_initial_o[7:4] == equalize_value_i[15:12]
			&& phy_equalize_functional_o[7:4] == equalize_value_i[11:8])
		else $error("port 2 equalizer wrong");
	chk_p3_deemph_sel: assert property (@(posedge clock_i) disable iff (!rst_n) // R1
		(ctrl_q[16] && NUM_PORTS > 2) |->
			phy_deemph_o[2*DE_W +: DE_W] == deemph_value_i[2*DE_W +: DE_W])
		else $error("port 3 de-emphasis wrong");
	chk_p4_deemph_sel: assert property (@(posedge clock_i) disable iff (!rst_n) // R12
		(ctrl_q[24] && NUM_PORTS > 2) |->
			phy_deemph_o[3*DE_W +: DE_W] == deemph_value_i[3*DE_W +: DE_W])
		else $error("port 4 de-emphasis wrong");
	chk_p4_amp_sel: assert property (@(posedge clock_i) disable iff (!rst_n) // R12
		(ctrl_q[25] && NUM_PORTS > 2) |->
			phy_tx_amplitude_o[3*AMP_W +: AMP_W] == tx_amplitude_value_i[3*AMP_W +: AMP_W])
		else $error("port 4 swing wrong");
	chk_p4_eq_sel: assert property (@(posedge clock_i) disable iff (!rst_n) // R11 R12
		(ctrl_q[26] && NUM_PORTS > 2) |->
			phy_equalize_initial_o[15:12] == equalize_value_i[31:28]
			&& phy_equalize_functional_o[15:12] == equalize_value_i[27:24])
		else $error("port 4 equalizer wrong");
	chk_absent_port_default: assert property (@(posedge clock_i) disable iff (!rst_n) // R2 R12
		NUM_PORTS == 2 |-> phy_deemph_o[2*DE_W +: DE_W] == deemph_default_i[2*DE_W +: DE_W]
			&& phy_deemph_o[3*DE_W +: DE_W] == deemph_default_i[3*DE_W +: DE_W])
		else $error("absent port changed");

	// ==========================================================
	// Checks: clear or absent override leaves the default
	// Absent ports are held to defaults whatever their stored bits say
	for (genvar p = 0; p < PTO_MAX_PORTS; p++) begin : g_chk_port
		chk_deemph_default: assert property (@(posedge clock_i) disable iff (!rst_n) // R2 R14
			(!ctrl_q[BASES[p] + PTO_DE_OFS] || p >= NUM_PORTS) |->
				phy_deemph_o[p*DE_W +: DE_W] == deemph_default_i[p*DE_W +: DE_W])
			else $error("de-emphasis not default");
		chk_amp_default: assert property (@(posedge clock_i) disable iff (!rst_n) // R12 R14
			(!ctrl_q[BASES[p] + PTO_AMP_OFS] || p >= NUM_PORTS) |->
				phy_tx_amplitude_o[p*AMP_W +: AMP_W] == tx_amplitude_default_i[p*AMP_W +: AMP_W])
			else $error("swing not default");
		chk_eq_default: assert property (@(posedge clock_i) disable iff (!rst_n) // R11 R14
			(!ctrl_q[BASES[p] + PTO_EQ_OFS] || p >= NUM_PORTS) |->
				phy_equalize_functional_o[p*PTO_EQ_W +: PTO_EQ_W] ==
					equalize_default_i[p*2*PTO_EQ_W + PTO_EQ_FUNC_LSB +: PTO_EQ_W]
				&& phy_equalize_initial_o[p*PTO_EQ_W +: PTO_EQ_W] ==
					equalize_default_i[p*2*PTO_EQ_W + PTO_EQ_INIT_LSB +: PTO_EQ_W])
			else $error("equalizer not default");
	end

	// ==========================================================
	// Checks: register and read path
	chk_reserved_zero: assert property (@(posedge clock_i) disable iff (!rst_n) // R3
		(ctrl_q & ~PTO_CTRL_WMASK) == 32'h0000_0000 && (cfg_rdata_o & ~PTO_CTRL_WMASK) == 32'h0)
		else $error("reserved bit set");
	chk_write_takes: assert property (@(posedge clock_i) disable iff (!rst_n) // R13
		(sel && cfg_wr_i && cfg_be_i == 4'hf) |=>
			ctrl_q == ($past(cfg_wdata_i) & PTO_CTRL_WMASK))
		else $error("write not stored");
	chk_read_data: assert property (@(posedge clock_i) disable iff (!rst_n) // R13
		(sel && cfg_rd_i) |=> cfg_rdata_o == ($past(ctrl_q) & PTO_CTRL_WMASK))
		else $error("read data wrong");
	chk_read_other: assert property (@(posedge clock_i) disable iff (!rst_n) // R13
		(!sel && cfg_rd_i) |=> cfg_rdata_o == 32'h0000_0000)
		else $error("foreign read not zero");
	chk_rdata_holds: assert property (@(posedge clock_i) disable iff (!rst_n) // R13
		!cfg_rd_i |=> $stable(cfg_rdata_o))
		else $error("read data moved without read");
	chk_reset_clears: assert property (@(posedge clock_i) // R10
		$rose(rst_n) |-> ctrl_q == PTO_CTRL_RESET)
		else $error("override bits survived reset");
endmodule : pto_ctrl

/* hw/pto_pkg.sv */
// Package: offsets, field positions and reset values of the PHY tuning override register
package pto_pkg;
	// ==========================================================
	// Register map
	localparam logic [11:0] PTO_CTRL_OFFSET = 12'h0ec;
	localparam logic [31:0] PTO_CTRL_RESET = 32'h0000_0000;
	// Writable bits: 26:24, 18:16, 10:8, 2:0
	localparam logic [31:0] PTO_CTRL_WMASK = 32'h0707_0707;
	// ==========================================================
	// Field positions
	localparam int PTO_P1_BASE = 0;
	localparam int PTO_P2_BASE = 8;
	localparam int PTO_P3_BASE = 16;
	localparam int PTO_P4_BASE = 24;
	localparam int PTO_DE_OFS = 0;
	localparam int PTO_AMP_OFS = 1;
	localparam int PTO_EQ_OFS = 2;
	localparam int PTO_EQ_FUNC_LSB = 0;
	localparam int PTO_EQ_INIT_LSB = 4;
	// ==========================================================
	// Widths
	localparam int PTO_EQ_W = 4;
	localparam int PTO_MAX_PORTS = 4;
	localparam int PTO_SMALL_PORTS = 2;
endpackage : pto_pkg

/* hw/pto_port_sel.sv */
// Per-port selection between built-in default and override values
`timescale 1ns/1ps
module pto_port_sel #(
	parameter int DE_W = 4,
	parameter int AMP_W = 4
) (
	// Enables
	input wire logic present_i,
	input wire logic deemph_override_en_i,
	input wire logic tx_amplitude_override_en_i,
	input wire logic rx_equalize_override_en_i,
	// Override values
	input wire logic [DE_W-1:0] deemph_value_i,
	input wire logic [AMP_W-1:0] tx_amplitude_value_i,
	input wire logic [2*pto_pkg::PTO_EQ_W-1:0] equalize_value_i,
	// Built-in defaults
	input wire logic [DE_W-1:0] deemph_default_i,
	input wire logic [AMP_W-1:0] tx_amplitude_default_i,
	input wire logic [2*pto_pkg::PTO_EQ_W-1:0] equalize_default_i,
	// PHY side
	output logic [DE_W-1:0] deemph_o,
	output logic [AMP_W-1:0] tx_amplitude_o,
	output logic [pto_pkg::PTO_EQ_W-1:0] equalize_functional_o,
	output logic [pto_pkg::PTO_EQ_W-1:0] equalize_initial_o
);
	import pto_pkg::*;
	logic [2*PTO_EQ_W-1:0] eq_sel;
	// Absent ports see defaults whatever the bit holds
	assign deemph_o = (present_i && deemph_override_en_i) ?
		deemph_value_i : deemph_default_i;
	assign tx_amplitude_o = (present_i && tx_amplitude_override_en_i) ?
		tx_amplitude_value_i : tx_amplitude_default_i;
	// Both equalizer halves switch together
	assign eq_sel = (present_i && rx_equalize_override_en_i) ?
		equalize_value_i : equalize_default_i;
	assign equalize_functional_o = eq_sel[PTO_EQ_FUNC_LSB +: PTO_EQ_W];
	assign equalize_initial_o = eq_sel[PTO_EQ_INIT_LSB +: PTO_EQ_W];
endmodule : pto_port_sel

/* verification/pto_phy_model.sv */
// PHY side model: companion value registers and built-in defaults
`timescale 1ns/1ps
module pto_phy_model (
	// Pattern select
	input wire logic [31:0] pat_i,
	// Companion values and defaults
	output logic [15:0] deemph_value_o,
	output logic [15:0] tx_amplitude_value_o,
	output logic [31:0] equalize_value_o,
	output logic [15:0] deemph_default_o,
	output logic [15:0] tx_amplitude_default_o,
	output logic [31:0] equalize_default_o
);
	// ==========================================================
	// Values
	// Defaults are the inverse, so a wrong mux choice always shows
	assign deemph_value_o = pat_i[15:0];
	assign tx_amplitude_value_o = pat_i[31:16];
	assign equalize_value_o = {pat_i[7:0], pat_i[31:8]};
	assign deemph_default_o = ~pat_i[15:0];
	assign tx_amplitude_default_o = ~pat_i[31:16];
	assign equalize_default_o = ~{pat_i[7:0], pat_i[31:8]};
endmodule : pto_phy_model

/* verification/test_pto_ctrl.sv */
// Testbench for the PHY tuning override register
`timescale 1ns/1ps
module test_pto_ctrl;
	import pto_pkg::*;
	logic clock_i;
	logic [2:0] rst_n;
	logic [11:0] addr;
	logic wr_s, rd_s, hit;
	logic [3:0] be;
	logic [31:0] wdata, rdata, rdata2, pat, ev, ed;
	logic [15:0] dv, av, dd, ad, pd, pa, pf, pn, d2, a2, f2, n2;
	int n_errors = 0;
	int cmp_count = 0;
	pto_phy_model pm_u (.pat_i(pat), .deemph_value_o(dv), .tx_amplitude_value_o(av),
		.equalize_value_o(ev), .deemph_default_o(dd), .tx_amplitude_default_o(ad),
		.equalize_default_o(ed));
	pto_ctrl dut_u (.clock_i(clock_i), .resetn_i(rst_n[0]), .fundamental_resetn_i(rst_n[1]),
		.global_reset_in_n_i(rst_n[2]), .cfg_addr_i(addr), .cfg_wr_i(wr_s), .cfg_be_i(be),
		.cfg_wdata_i(wdata), .cfg_rd_i(rd_s), .cfg_rdata_o(rdata), .cfg_hit_o(hit),
		.deemph_value_i(dv), .tx_amplitude_value_i(av), .equalize_value_i(ev),
		.deemph_default_i(dd), .tx_amplitude_default_i(ad), .equalize_default_i(ed),
		.phy_deemph_o(pd), .phy_tx_amplitude_o(pa), .phy_equalize_functional_o(pf),
		.phy_equalize_initial_o(pn));
	// Two-port variant shares every input; its reads must match the full one
	pto_ctrl #(.NUM_PORTS(2)) dut2_u (.clock_i(clock_i), .resetn_i(rst_n[0]),
		.fundamental_resetn_i(rst_n[1]), .global_reset_in_n_i(rst_n[2]), .cfg_addr_i(addr),
		.cfg_wr_i(wr_s), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_rd_i(rd_s),
		.cfg_rdata_o(rdata2), .cfg_hit_o(), .deemph_value_i(dv), .tx_amplitude_value_i(av),
		.equalize_value_i(ev), .deemph_default_i(dd), .tx_amplitude_default_i(ad),
		.equalize_default_i(ed), .phy_deemph_o(d2), .phy_tx_amplitude_o(a2),
		.phy_equalize_functional_o(f2), .phy_equalize_initial_o(n2));
	// ==========================================================
	// Tasks
	task automatic complete_run();
		if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
		@(negedge clock_i);
		addr = a;
		be = b;
		wdata = d;
		wr_s = 1'b1;
		@(negedge clock_i);
		wr_s = 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic h, input logic [31:0] e);
		@(negedge clock_i);
		addr = a;
		rd_s = 1'b1;
		#1 cmp({31'h0, hit}, {31'h0, h});
		@(negedge clock_i);
		rd_s = 1'b0;
		cmp(rdata, e);
		cmp(rdata2, e);
	endtask : rd
	task automatic chk_phy(input logic [31:0] c);
		logic [15:0] de, am, fu, ini;
		logic [2:0] en;
		#1;
		for (int k = 0; k < 2; k++) begin
			for (int p = 0; p < 4; p++) begin
				en = (k == 1 && p > 1) ? 3'h0 : c[8*p+:3];
				de[4*p+:4] = en[0] ? dv[4*p+:4] : dd[4*p+:4];
				am[4*p+:4] = en[1] ? av[4*p+:4] : ad[4*p+:4];
				fu[4*p+:4] = en[2] ? ev[8*p+:4] : ed[8*p+:4];
				ini[4*p+:4] = en[2] ? ev[8*p+4+:4] : ed[8*p+4+:4];
			end
			cmp({16'h0, k ? d2 : pd}, {16'h0, de});
			cmp({16'h0, k ? a2 : pa}, {16'h0, am});
			cmp(k ? {f2, n2} : {pf, pn}, {fu, ini});
		end
	endtask : chk_phy
	// ==========================================================
	// Clock, watchdog and sequence
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	initial begin
		repeat (3000) @(posedge clock_i);
		n_errors++;
		complete_run();
	end
	initial begin
		{rst_n, wr_s, rd_s, be, addr, wdata} = '0;
		pat = 32'h5a3c_96e1;
		repeat (10) @(negedge clock_i);
		rst_n = 3'h7;
		rd(PTO_CTRL_OFFSET, 1'b1, 32'h0);
		chk_phy(32'h0);
		for (int b = 0; b < 32; b++) begin
			wr(PTO_CTRL_OFFSET, 4'hf, 32'h1 << b);
			rd(PTO_CTRL_OFFSET, 1'b1, (32'h1 << b) & 32'h0707_0707);
			chk_phy((32'h1 << b) & 32'h0707_0707);
		end
		// Byte lanes are independent
		wr(PTO_CTRL_OFFSET, 4'h5, 32'hffff_ffff);
		rd(PTO_CTRL_OFFSET, 1'b1, 32'h0007_0007);
		wr(PTO_CTRL_OFFSET, 4'h4, 32'h0);
		rd(PTO_CTRL_OFFSET, 1'b1, 32'h0000_0007);
		wr(PTO_CTRL_OFFSET, 4'hf, 32'hffff_ffff);
		pat = 32'hc3a5_1e78;
		chk_phy(32'h0707_0707);
		// Other addresses neither hit nor disturb the register
		wr(12'h0f0, 4'hf, 32'h0);
		rd(12'h0e8, 1'b0, 32'h0);
		rd(PTO_CTRL_OFFSET, 1'b1, 32'h0707_0707);
		for (int r = 0; r < 3; r++) begin
			wr(PTO_CTRL_OFFSET, 4'hf, 32'hffff_ffff);
			rst_n[r] = 1'b0;
			@(negedge clock_i);
			rst_n[r] = 1'b1;
			rd(PTO_CTRL_OFFSET, 1'b1, 32'h0);
			chk_phy(32'h0);
		end
		complete_run();
	end
endmodule : test_pto_ctrl
